// *** rtl/pums_pkg.sv ***
// Constants, states and carriers for the power-up mode sequencer.
// Assumes a single 10 MHz clock and an APB register port.
package pums_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int ADD_DELAY_MS  = 50;
	localparam int POR_SHORT_US  = 2000;
	localparam int POR_LONG_US   = 100000;
	localparam int OSC_HZ_DEF    = 10000;
	localparam int POR_SHORT_CYC = (CLK_HZ / 1000000) * POR_SHORT_US;
	localparam int POR_LONG_CYC  = (CLK_HZ / 1000000) * POR_LONG_US;
	localparam int SUPPLY_XTRA_CYC = 16;
	localparam int INIT_STEP_CYC = 4;
	localparam int CNT_W         = 24;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] STAT_OFS  = 8'h04;
	localparam int         CTRL_RESTART_BIT = 0;
	localparam int         CTRL_CLRSEEN_BIT = 1;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	// ==========================================================
	// States
	typedef enum logic [2:0] {
		ST_POR  = 3'h0,
		ST_HOLD = 3'h1,
		ST_WAIT = 3'h2,
		ST_INIT = 3'h3,
		ST_USER = 3'h4
	} pums_state_t;

	typedef enum logic [1:0] {
		STEP_REGS = 2'h0,
		STEP_CLKS = 2'h1,
		STEP_IO   = 2'h2
	} pums_step_t;

	// ==========================================================
	// Status word
	typedef struct packed {
		logic [19:0] rsvd;
		logic        restartSeen;
		logic        flagPin;
		logic        statusPin;
		logic        chainInLow;
		logic        pullupEn;
		logic        ioEn;
		logic        initComplete;
		logic        optDelayed;
		logic        optInitComplete;
		pums_state_t state;
	} pums_status_t;

endpackage : pums_pkg

// *** rtl/pums_delay_counter.sv ***
// Saturating delay counter with clear and tick enable.
// Assumes tick is synchronous to clk.
`timescale 1ns/1ps
module pums_delay_counter #(
	parameter int W = 24
) (
	input  wire logic         clk,    // System clock
	input  wire logic         reset,  // Sync reset, high
	input  wire logic         clear,  // Restart count
	input  wire logic         tick,   // Count enable
	input  wire logic [W-1:0] limit,  // Terminal count
	output logic              done    // Count reached
);
	logic [W-1:0] cnt_ff;

	assign done = (cnt_ff >= limit);

	always_ff @(posedge clk)
	begin
		if (reset || clear)
			cnt_ff <= '0;
		else if (tick && !done)
			cnt_ff <= cnt_ff + 1'b1;
	end

	chk_cnt_sticky: assert property (@(posedge clk) disable iff (reset)
		done && !clear |=> done)
		else $error("delay counter lost done");

endmodule : pums_delay_counter

// *** rtl/pums_sequencer.sv ***
// Power-up sequencer: reset delay, optional added delay, init phase.
// Assumes all pins synchronous to clk; open-drain pins resolved outside.
`timescale 1ns/1ps

module pums_sequencer import pums_pkg::*; #(
	parameter bit              ADDED_DELAY_OPT  = 1'b0,
	parameter bit              HAS_PULLUP_DIS   = 1'b1,
	parameter bit              INIT_COMPLETE_EN = 1'b1,
	parameter int              OSC_HZ           = OSC_HZ_DEF,
	parameter logic [CNT_W-1:0] POR_SHORT       = CNT_W'(POR_SHORT_CYC),
	parameter logic [CNT_W-1:0] POR_LONG        = CNT_W'(POR_LONG_CYC)
) (
	input  wire logic  clk,                  // System clock
	input  wire logic  reset,                // Power-on reset, sync high
	input  wire logic  psel,                 // APB select
	input  wire logic  penable,              // APB enable
	input  wire logic  pwrite,               // APB direction
	input  wire logic [7:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic [31:0] prdata,              // APB read data
	output logic       pready,               // APB ready
	output logic       pslverr,              // APB error
	input  wire logic  oscTick,              // On-chip oscillator tick
	input  wire logic  restartRequestLow,    // Restart pin, low active
	input  wire logic  deviceStatusLowIn,    // Status pin level
	output logic       deviceStatusLowOut,   // Status pin drive value
	output logic       deviceStatusLowOe,    // Status pin pulled low
	input  wire logic  configCompleteFlagIn, // Done flag pin level
	output logic       configCompleteFlagOut,// Done flag drive value
	output logic       configCompleteFlagOe, // Done flag pulled low
	input  wire logic  chainEnableInLow,     // Chain enable in, low active
	output logic       chainEnableOutLow,    // Chain enable out, low active
	input  wire logic  pullupDisable,        // Weak pull-up disable
	input  wire logic  porDelaySelect,       // Long reset delay select
	input  wire logic  supplyLevelSelect,    // Supply level select
	output logic       weakPullupEn,         // Weak I/O pull-ups on
	output logic       userRegReset,         // User register reset
	output logic       clkGenInit,           // Clock generator init
	output logic       userIoEnable,         // User I/O enable
	output logic       initComplete          // Init complete, optional
);
	import pums_pkg::*;

	// ==========================================================
	// Derived counts
	localparam int ADD_TICKS_I = (OSC_HZ * ADD_DELAY_MS + 999) / 1000;
	localparam logic [CNT_W-1:0] ADD_TICKS = CNT_W'(ADD_TICKS_I);
	localparam logic [CNT_W-1:0] STEP_LIM  = CNT_W'(INIT_STEP_CYC);
	localparam logic [CNT_W-1:0] SUP_XTRA  = CNT_W'(SUPPLY_XTRA_CYC);

	pums_state_t      state_ff;
	pums_state_t      nxtState;
	pums_step_t       initStep_ff;
	logic             delayPassed_ff;
	logic             flagOe_ff;
	logic             statusOe_ff;
	logic             chainLow_ff;
	logic             pullup_ff;
	logic             regRst_ff;
	logic             clkInit_ff;
	logic             ioEn_ff;
	logic             initDone_ff;
	logic             restartSeen_ff;
	logic [31:0]      prdata_ff;
	logic             porDone;
	logic             addDone;
	logic             stepDone;
	logic [CNT_W-1:0] porLimit;
	pums_status_t     statusWord;

	// ==========================================================
	// APB slave
	wire apbSetup   = psel && !penable;
	wire apbAccess  = psel && penable;
	wire hitCtrl    = (paddr == CTRL_OFS);
	wire hitStat    = (paddr == STAT_OFS);
	wire ctrlWrite  = apbAccess && pwrite && hitCtrl;
	wire softRestart = ctrlWrite && pwdata[CTRL_RESTART_BIT];
	wire clrSeen    = ctrlWrite && pwdata[CTRL_CLRSEEN_BIT];
	wire [31:0] rdMux = hitStat ? statusWord : RD_ZERO;

	assign pready  = 1'b1;
	assign pslverr = apbAccess && !(hitCtrl || hitStat);
	assign prdata  = prdata_ff;

	// Read data captured in setup so it is stable through access
	always_ff @(posedge clk)
	begin
		if (reset)
			prdata_ff <= RD_ZERO;
		else if (apbSetup)
			prdata_ff <= rdMux;
	end

	// ==========================================================
	// Delay counters
	// Pin select for the delay length; no emulation path exists
	assign porLimit = (porDelaySelect ? POR_LONG : POR_SHORT)
		+ (supplyLevelSelect ? SUP_XTRA : '0);

	pums_delay_counter #(.W(CNT_W)) u_porCnt (
		.clk   (clk),
		.reset (reset),
		.clear (state_ff != ST_POR),
		.tick  (1'b1),
		.limit (porLimit),
		.done  (porDone)
	);

	// Oscillator ticks only; the user clock never advances it
	pums_delay_counter #(.W(CNT_W)) u_addCnt (
		.clk   (clk),
		.reset (reset),
		.clear (state_ff != ST_WAIT),
		.tick  (oscTick),
		.limit (ADD_TICKS),
		.done  (addDone)
	);

	pums_delay_counter #(.W(CNT_W)) u_stepCnt (
		.clk   (clk),
		.reset (reset),
		.clear ((state_ff != ST_INIT) || stepDone),
		.tick  (1'b1),
		.limit (STEP_LIM),
		.done  (stepDone)
	);

	// ==========================================================
	// Sequencer
	wire restartActive = !restartRequestLow || softRestart;
	wire addedOpt      = ADDED_DELAY_OPT;
	wire afterHold     = addedOpt && !delayPassed_ff;

	always_comb
	begin
		nxtState = state_ff;
		unique case (state_ff)
			ST_POR:
				if (porDone)
				begin
					// Held restart postpones init
					if (!restartRequestLow)
						nxtState = ST_HOLD;
					else if (addedOpt)
						nxtState = ST_WAIT;
					else
						nxtState = ST_INIT;
				end
			ST_HOLD:
				if (!restartActive)
					nxtState = afterHold ? ST_WAIT : ST_INIT;
			ST_WAIT:
				if (restartActive)
					nxtState = ST_HOLD;
				else if (addDone)
					nxtState = ST_INIT;
			ST_INIT:
				if (restartActive)
					nxtState = ST_HOLD;
				else if (initStep_ff == STEP_IO && stepDone)
					nxtState = ST_USER;
			ST_USER:
				if (restartActive)
					nxtState = ST_HOLD;
			default:
				nxtState = ST_POR;
		endcase
	end

	// Restart re-runs init only; a done added delay is not repeated
	always_ff @(posedge clk)
	begin
		if (reset)
			delayPassed_ff <= 1'b0;
		else if (state_ff == ST_WAIT && addDone)
			delayPassed_ff <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_ff <= ST_POR;
		else
			state_ff <= nxtState;
	end

	always_ff @(posedge clk)
	begin
		if (reset || state_ff != ST_INIT)
			initStep_ff <= STEP_REGS;
		else if (stepDone && initStep_ff != STEP_IO)
			initStep_ff <= pums_step_t'(initStep_ff + 2'h1);
	end

	// ==========================================================
	// Pin drives
	wire nxtLive    = (nxtState == ST_INIT) || (nxtState == ST_USER);
	wire nxt_flagOe = !nxtLive;
	wire nxt_statOe = (nxtState == ST_POR) || (nxtState == ST_HOLD);
	// Chain only passes on when this device is itself enabled
	wire nxt_chainLow = !(nxtLive && !chainEnableInLow);
	// Pull-up disable honoured only where the disable input exists
	wire pullupOff  = HAS_PULLUP_DIS && pullupDisable;
	wire nxt_pullup = (nxtState != ST_USER) && !pullupOff;
	wire inInit     = (state_ff == ST_INIT);
	wire nxt_regRst = inInit && initStep_ff == STEP_REGS;
	wire nxt_clkIni = inInit && initStep_ff == STEP_CLKS;
	wire nxt_ioEn   = (inInit && initStep_ff == STEP_IO) || state_ff == ST_USER;
	// Needs the flag actually high on the pin, not just released
	wire nxt_initDone = INIT_COMPLETE_EN && nxtState == ST_USER
		&& (initDone_ff || configCompleteFlagIn);
	wire enterHold  = (nxtState == ST_HOLD) && (state_ff != ST_HOLD);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flagOe_ff   <= 1'b1;
			statusOe_ff <= 1'b1;
			chainLow_ff <= 1'b1;
			pullup_ff   <= 1'b1;
			regRst_ff   <= 1'b0;
			clkInit_ff  <= 1'b0;
			ioEn_ff     <= 1'b0;
			initDone_ff <= 1'b0;
		end
		else
		begin
			flagOe_ff   <= nxt_flagOe;
			statusOe_ff <= nxt_statOe;
			chainLow_ff <= nxt_chainLow;
			pullup_ff   <= nxt_pullup;
			regRst_ff   <= nxt_regRst;
			clkInit_ff  <= nxt_clkIni;
			ioEn_ff     <= nxt_ioEn;
			initDone_ff <= nxt_initDone;
		end
	end

	// Entry to hold wins over a software clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset)
			restartSeen_ff <= 1'b0;
		else
			restartSeen_ff <= enterHold || (restartSeen_ff && !clrSeen);
	end

	assign configCompleteFlagOut = 1'b0;
	assign configCompleteFlagOe  = flagOe_ff;
	assign deviceStatusLowOut    = 1'b0;
	assign deviceStatusLowOe     = statusOe_ff;
	assign chainEnableOutLow     = chainLow_ff;
	assign weakPullupEn          = pullup_ff;
	assign userRegReset          = regRst_ff;
	assign clkGenInit            = clkInit_ff;
	assign userIoEnable          = ioEn_ff;
	assign initComplete          = initDone_ff;

	always_comb
	begin
		statusWord                 = '0;
		statusWord.restartSeen     = restartSeen_ff;
		statusWord.flagPin         = configCompleteFlagIn;
		statusWord.statusPin       = deviceStatusLowIn;
		statusWord.chainInLow      = chainEnableInLow;
		statusWord.pullupEn        = pullup_ff;
		statusWord.ioEn            = ioEn_ff;
		statusWord.initComplete    = initDone_ff;
		statusWord.optDelayed      = ADDED_DELAY_OPT;
		statusWord.optInitComplete = INIT_COMPLETE_EN;
		statusWord.state           = state_ff;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_flag_por_low: assert property (
		state_ff == ST_POR |-> configCompleteFlagOe)
		else $error("done flag not held low in reset delay");
	chk_flag_released: assert property (
		state_ff != ST_INIT ##1 state_ff == ST_INIT |-> !configCompleteFlagOe)
		else $error("done flag not released at init");
	chk_added_wait: assert property (
		state_ff == ST_POR && porDone && restartRequestLow && addedOpt
		|=> state_ff == ST_WAIT && configCompleteFlagOe)
		else $error("added delay skipped");
	chk_instant_init: assert property (
		state_ff == ST_POR && porDone && restartRequestLow && !addedOpt
		|=> state_ff == ST_INIT)
		else $error("instant option did not enter init");
	chk_osc_only: assert property (
		state_ff == ST_WAIT && !oscTick && !addDone && restartRequestLow
		&& !softRestart |=> state_ff == ST_WAIT)
		else $error("added delay advanced without oscillator");
	chk_chain_flag: assert property (
		!chainEnableOutLow |-> !configCompleteFlagOe && !$past(chainEnableInLow))
		else $error("chain output asserted with flag held");
	chk_pullup_off: assert property (
		HAS_PULLUP_DIS && pullupDisable |=> !weakPullupEn)
		else $error("pull-ups on while disabled");
	chk_pullup_user: assert property (
		state_ff == ST_USER |-> !weakPullupEn)
		else $error("pull-ups left on in user mode");
	chk_restart_hold: assert property (
		state_ff != ST_POR && !restartRequestLow
		|=> state_ff == ST_HOLD && configCompleteFlagOe)
		else $error("restart did not restart init");
	chk_hold_stays: assert property (
		state_ff == ST_HOLD && !restartRequestLow |=> state_ff == ST_HOLD)
		else $error("init began while restart held");
	chk_initdone_late: assert property (
		$rose(initComplete) |-> $past(configCompleteFlagIn) && state_ff == ST_USER)
		else $error("init complete rose before done flag");

	cov_user: cover property (state_ff == ST_INIT ##1 state_ff == ST_USER);
	cov_wait: cover property (state_ff == ST_WAIT ##1 state_ff == ST_INIT);
	cov_restart: cover property (state_ff == ST_USER ##1 state_ff == ST_HOLD);
	cov_hold_exit: cover property (state_ff == ST_HOLD ##1 state_ff != ST_HOLD);

endmodule : pums_sequencer

// *** testbench/pums_board_model.sv ***
// Board-side model: pull-ups on the open-drain pins, restart and chain pins,
// and the free-running on-chip oscillator tick.
// Assumes the bench sets restartReq and chainOff just after rising edges.
`timescale 1ns/1ps
module pums_board_model (
	input  wire logic clk,        // System clock
	input  wire logic flagOe,     // Done flag pulled low
	input  wire logic flagOut,    // Done flag drive value
	input  wire logic statusOe,   // Status pin pulled low
	input  wire logic statusOut,  // Status drive value
	input  wire logic restartReq, // Bench asks for restart
	input  wire logic chainOff,   // Bench keeps chain input high
	output logic      flagPin,    // Resolved done flag
	output logic      statusPin,  // Resolved status pin
	output logic      restartLow, // Restart pin
	output logic      chainInLow, // Chain enable in
	output logic      oscTick     // Oscillator tick
);
	logic [2:0] oscCnt_ff = 3'h0;

	// ==========================================================
	// Pins
	// Board only pulls up the flag and status pins; it never drives those low
	assign flagPin    = flagOe ? flagOut : 1'b1;
	assign statusPin  = statusOe ? statusOut : 1'b1;
	assign restartLow = ~restartReq;
	assign chainInLow = chainOff;
	// Slow oscillator, one tick every eight clocks, never stops
	assign oscTick    = (oscCnt_ff == 3'h7);

	always_ff @(posedge clk)
	begin
		oscCnt_ff <= oscCnt_ff + 3'h1;
	end
endmodule : pums_board_model

// *** testbench/test_power_up_mode_sequencer.sv ***
// Self-checking bench for the power-up sequencer, delayed and instant options built.
// Assumes pums_pkg, the sequencer and the board model are compiled first.
`timescale 1ns/1ps
module test_power_up_mode_sequencer;
	import pums_pkg::*;
	localparam int POR_S = 20;
	localparam int POR_L = 40;
	localparam int TOUT  = 200;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        oscTick, restartLow, statusPin, statusOut, statusOe, chainInLow;
	logic        flagPin, flagOut, flagOe, chainOut, restartReq, chainOff;
	logic        pullupDisable, porDelaySelect, supplyLevelSelect, weakPullupEn;
	logic        userRegReset, clkGenInit, userIoEnable, initComplete, seenRegs, seenClks;
	logic        flagOe2, flagOut2, flagPin2, statusOe2, statusOut2, statusPin2;
	logic        pullup2, initDone2;
	int          errors, cmpCount, cyc;
	integer      seed;

	// ==========================================================
	// Instances
	pums_sequencer #(.ADDED_DELAY_OPT(1'b1), .HAS_PULLUP_DIS(1'b1), .INIT_COMPLETE_EN(1'b1),
		.OSC_HZ(100), .POR_SHORT(CNT_W'(POR_S)), .POR_LONG(CNT_W'(POR_L))) dut (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.oscTick(oscTick), .restartRequestLow(restartLow), .deviceStatusLowIn(statusPin),
		.deviceStatusLowOut(statusOut), .deviceStatusLowOe(statusOe),
		.configCompleteFlagIn(flagPin), .configCompleteFlagOut(flagOut),
		.configCompleteFlagOe(flagOe), .chainEnableInLow(chainInLow),
		.chainEnableOutLow(chainOut), .pullupDisable(pullupDisable),
		.porDelaySelect(porDelaySelect), .supplyLevelSelect(supplyLevelSelect),
		.weakPullupEn(weakPullupEn), .userRegReset(userRegReset), .clkGenInit(clkGenInit),
		.userIoEnable(userIoEnable), .initComplete(initComplete));
	pums_board_model board (.clk(clk), .flagOe(flagOe), .flagOut(flagOut),
		.statusOe(statusOe), .statusOut(statusOut), .restartReq(restartReq),
		.chainOff(chainOff), .flagPin(flagPin), .statusPin(statusPin),
		.restartLow(restartLow), .chainInLow(chainInLow), .oscTick(oscTick));
	// Instant option, no pull-up disable input, no init-complete output
	pums_sequencer #(.ADDED_DELAY_OPT(1'b0), .HAS_PULLUP_DIS(1'b0), .INIT_COMPLETE_EN(1'b0),
		.OSC_HZ(100), .POR_SHORT(CNT_W'(POR_S)), .POR_LONG(CNT_W'(POR_L))) dut2 (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.oscTick(oscTick), .restartRequestLow(restartLow), .deviceStatusLowIn(statusPin2),
		.deviceStatusLowOut(statusOut2), .deviceStatusLowOe(statusOe2),
		.configCompleteFlagIn(flagPin2), .configCompleteFlagOut(flagOut2),
		.configCompleteFlagOe(flagOe2), .chainEnableInLow(chainInLow),
		.chainEnableOutLow(), .pullupDisable(pullupDisable),
		.porDelaySelect(porDelaySelect), .supplyLevelSelect(supplyLevelSelect),
		.weakPullupEn(pullup2), .userRegReset(), .clkGenInit(),
		.userIoEnable(), .initComplete(initDone2));
	pums_board_model board2 (.clk(clk), .flagOe(flagOe2), .flagOut(flagOut2),
		.statusOe(statusOe2), .statusOut(statusOut2), .restartReq(restartReq),
		.chainOff(chainOff), .flagPin(flagPin2), .statusPin(statusPin2),
		.restartLow(), .chainInLow(), .oscTick());

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ==========================================================
	// Helpers
	task automatic give_verdict();
		if (errors == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic bound_hit();
		chk("wait bound", 0, 1);
		give_verdict();
	endtask : bound_hit

	function automatic logic rbit();
		return 1'($random(seed));
	endfunction : rbit

	function automatic int por_cycles(input logic sup, input logic lng);
		return (lng ? POR_L : POR_S) + (sup ? SUPPLY_XTRA_CYC : 0);
	endfunction : por_cycles

	// Called just after a rising edge; ends one edge after the access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < TOUT);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= TOUT)
			bound_hit();
	endtask : apb

	// Sel 0 waits on the flag drive, 1 on init-complete
	task automatic wait_for(input int sel, input logic v);
		int n;
		n = 0;
		while (((sel == 0) ? flagOe : initComplete) !== v && n < TOUT)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= TOUT)
			bound_hit();
	endtask : wait_for

	// ==========================================================
	// Monitor
	always @(posedge clk)
	begin
		cyc <= reset ? 0 : cyc + 1;
		seenRegs <= !reset && (seenRegs || userRegReset === 1'b1);
		seenClks <= !reset && (seenClks || clkGenInit === 1'b1);
		if (!reset && initComplete === 1'b1)
			chk("flag before init done", 1, flagPin);
	end

	// ==========================================================
	// Power-up run with random pin straps
	task automatic power_up(input logic holdR);
		int lo;
		reset             <= 1'b1;
		pullupDisable     <= rbit();
		supplyLevelSelect <= rbit();
		porDelaySelect    <= rbit();
		chainOff          <= rbit();
		restartReq        <= holdR;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("flag held", 1, flagOe);
		chk("init done low", 0, initComplete);
		// Pull-up flops take the strap one edge after reset is released
		@(posedge clk);
		chk("pull-ups", !pullupDisable, weakPullupEn);
		chk("pull-ups kept", 1, pullup2);
		chk("status held", 1, statusOe);
		lo = por_cycles(supplyLevelSelect, porDelaySelect);
		if (holdR)
		begin
			while (cyc < lo + 10)
				@(posedge clk);
			apb(1'b0, STAT_OFS, 32'h0000_0000);
			chk("state hold", ST_HOLD, rd[2:0]);
			chk("flag in hold", 1, flagOe);
			restartReq <= 1'b0;
			lo = cyc;
		end
		else
		begin
			while (cyc < lo + 2)
				@(posedge clk);
			chk("instant release", 0, flagOe2);
			chk("delayed held", 1, flagOe);
			apb(1'b0, STAT_OFS, 32'h0000_0000);
			chk("state wait", ST_WAIT, rd[2:0]);
			chk("options", 2'b11, rd[4:3]);
		end
		wait_for(0, 1'b0);
		chk("release time", 1, cyc >= lo + 30 && cyc <= lo + 56);
		chk("chain out", chainOff, chainOut);
		chk("pull-ups in init", !pullupDisable, weakPullupEn);
		wait_for(1, 1'b1);
		chk("flag pin", 1, flagPin);
		chk("pull-ups off", 0, weakPullupEn);
		chk("io enabled", 1, userIoEnable);
		chk("init steps", 2'b11, {seenRegs, seenClks});
		chk("status released", 0, statusOe);
		chk("no init done pin", 0, initDone2);
		chk("pull-ups off 2", 0, pullup2);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		chk("state user", {holdR, 2'b11, chainOff, 5'b0_1111, ST_USER}, rd[11:0]);
		// Restart pin pulse in user mode
		restartReq <= 1'b1;
		@(posedge clk);
		restartReq <= 1'b0;
		@(posedge clk);
		chk("restart flag", 1, flagOe);
		chk("restart status", 1, statusOe);
		chk("restart init done", 0, initComplete);
		wait_for(0, 1'b0);
		wait_for(1, 1'b1);
		// Register side: clear, soft restart, reads, refusals
		apb(1'b1, CTRL_OFS, 32'h0000_0002);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		chk("seen cleared", 0, rd[11]);
		apb(1'b1, CTRL_OFS, 32'h0000_0001);
		wait_for(1, 1'b1);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		chk("soft restart seen", 1, rd[11]);
		apb(1'b0, CTRL_OFS, 32'h0000_0000);
		chk("ctrl reads zero", 0, rd);
		apb(1'b1, STAT_OFS, 32'hffff_ffff);
		chk("status write err", 0, err);
		apb(1'b0, 8'h08 + 8'(($unsigned($random(seed)) % 62) * 4), 32'h0000_0000);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		apb(1'b0, STAT_OFS, 32'h0000_0000);
		chk("option fixed", {2'b11, ST_USER}, {rd[4:3], rd[2:0]});
	endtask : power_up

	// ==========================================================
	// Main sequence
	initial
	begin
		seed = 32'hdf9a_0933;
		errors = 0;
		cmpCount = 0;
		{reset, psel, penable, pwrite, restartReq, chainOff} = 6'b10_0000;
		{pullupDisable, porDelaySelect, supplyLevelSelect} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		@(posedge clk);
		for (int i = 0; i < 4; i++)
			power_up(i == 1);
		give_verdict();
	end
endmodule : test_power_up_mode_sequencer
